// File: design/sels_cfg.svh
/*
 * Offsets, bit positions, reset values and counts of the STOP-exit and
 * limp-home sequencer. Assumes inclusion by bare name from design files.
 */
`ifndef SELS_CFG_SVH
`define SELS_CFG_SVH

// register byte offsets (low address bits)
`define SELS_OFF_CTRL 12'h000
`define SELS_OFF_CLKSEL 12'h004
`define SELS_OFF_SLOW 12'h008
`define SELS_OFF_STAT 12'h00c

// control register fields
`define SELS_B_NO_LIMP 0
`define SELS_B_IRQ_EN 1
`define SELS_B_PSEUDO_EN 2
`define SELS_B_AUTO_BW 3
`define SELS_B_MON_EN 4
`define SELS_B_FMON_EN 5
`define SELS_B_DELAY_SEL 6
`define SELS_CTRL_W 7
`define SELS_CTRL_RST 7'h18

// clock select register fields
`define SELS_B_PLL_SEL 0
`define SELS_B_SLOW_SEL 1
`define SELS_CLKSEL_RST 2'h0

// slow divider register
`define SELS_SLOW_W 6
`define SELS_SLOW_RST 6'h00

// status register fields
`define SELS_B_LIMP_STAT 0
`define SELS_B_LIMP_CHG 1
`define SELS_B_STOPPED 2
`define SELS_B_PSEUDO 3
`define SELS_B_LIMP_FORCE 4

// exit delay counter
`define SELS_CNT_W 13
`define SELS_DONE_BIT 12
`define SELS_SHORT_CNT 13'h0010

// counter clock divider
`define SELS_DIV_W 8
`define SELS_DIV_BYPASS 8'h02
`define SELS_VCO_DIV 8'h08

`endif

// File: design/sels_counter_clock_gen.sv
/*
 * Counter clock tick generator: one hclk-wide tick per counter clock cycle.
 * Assumes hclk stands for the oscillator clock; the limp-home VCO is modelled
 * by a fixed divide while vco_select is high.
 */
`include "sels_cfg.svh"

module sels_cnt_clk_gen #(
    parameter logic [`SELS_DIV_W-1:0] VCO_DIV = `SELS_VCO_DIV
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // divider control
    input wire logic [`SELS_SLOW_W-1:0] slow_div,
    input wire logic vco_select,
    // counter clock tick
    output logic tick
);
    import sels_pkg::*;

    logic [`SELS_DIV_W-1:0] cnt_q, cnt_d;
    logic [`SELS_DIV_W-1:0] period;
    logic tick_q, tick_d;

    // slow divider gives 2*slow, counter clock halves it again
    always_comb begin
        if (vco_select) begin
            period = VCO_DIV;
        end else if (slow_div == '0) begin
            period = `SELS_DIV_BYPASS;
        end else begin
            period = {slow_div, 2'b00};
        end
        tick_d = (cnt_q >= period - 8'h01);
        cnt_d = tick_d ? '0 : cnt_q + 8'h01;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

// File: design/sels_pkg.sv
/*
 * Types of the STOP-exit and limp-home sequencer.
 * Assumes nothing of its surroundings.
 */
package sels_pkg;

    typedef enum logic [3:0] {
        SELS_RUN = 4'b0001,
        SELS_STOP = 4'b0010,
        SELS_WAIT = 4'b0100,
        SELS_SHORT = 4'b1000
    } sels_state_e;

    typedef logic [1:0] sels_trans_t;

endpackage

// File: design/sels_sequencer.sv
/*
 * STOP and pseudo-STOP exit sequencer with limp-home control, AHB-Lite slave.
 * Assumes a single hclk domain; wake pins and the clock monitor result are
 * asynchronous; stop_req is a one-cycle pulse from logic on hclk.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`include "sels_cfg.svh"

module sels_sequencer #(
    parameter int SYNC_N = 7
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire sels_pkg::sels_trans_t htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // cpu stop instruction
    input wire logic stop_req,
    // wake requests and clock monitor, asynchronous, active high
    input wire logic ext_reset_wake,
    input wire logic irq_pin,
    input wire logic nonmaskable_interrupt_pin,
    input wire logic key_wake_j,
    input wire logic key_wake_h,
    input wire logic can_wake,
    input wire logic ext_clock_present,
    // clock control
    output logic chip_release,
    output logic osc_low_amplitude,
    output logic vco_run,
    output logic bus_clock_pll_select_eff,
    output logic module_clock_slow_select_eff,
    output logic clock_monitor_enable_eff,
    output logic pll_relock_req,
    output logic clock_monitor_reset,
    output logic limp_home_irq_req,
    output sels_pkg::sels_state_e seq_state
);
    import sels_pkg::*;

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
        is_reg = (a[11:2] == off[11:2]);
    endfunction

    // synchronisers
    logic [SYNC_N-1:0] async_in, sync1_q, sync2_q;
    logic wake_s, clk_ok_s;

    assign async_in = {ext_clock_present, can_wake, key_wake_h, key_wake_j,
                       nonmaskable_interrupt_pin, irq_pin, ext_reset_wake};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign wake_s = |sync2_q[SYNC_N-2:0];
    assign clk_ok_s = sync2_q[SYNC_N-1];

    // bus
    logic [11:0] addr_q, addr_d;
    logic wr_q, wr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic ap;

    // configuration
    logic [`SELS_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [1:0] clksel_q, clksel_d;
    logic [`SELS_SLOW_W-1:0] slow_q, slow_d;

    // sequencer
    sels_state_e st_q, st_d;
    logic [`SELS_CNT_W-1:0] cnt_q, cnt_d, cnt_inc;
    logic limp_q, limp_d, lstat_q, lstat_d, flag_q, flag_d;
    logic pseudo_q, pseudo_d, relock_q, relock_d, cmrst_q, cmrst_d;
    logic tick, seq_tick, flag_clr, check_hit;
    logic no_limp, mon_any, delay_sel, auto_bw, pll_sel;

    assign no_limp = ctrl_q[`SELS_B_NO_LIMP];
    assign mon_any = ctrl_q[`SELS_B_MON_EN] | ctrl_q[`SELS_B_FMON_EN];
    assign delay_sel = ctrl_q[`SELS_B_DELAY_SEL];
    assign auto_bw = ctrl_q[`SELS_B_AUTO_BW];
    assign pll_sel = clksel_q[`SELS_B_PLL_SEL];

    // counter clock from the slow divider, VCO while limp forcing is on
    sels_cnt_clk_gen u_cnt_clk (
        .hclk(hclk),
        .hresetn(hresetn),
        .slow_div(slow_q),
        .vco_select(limp_q),
        .tick(tick)
    );

    // without limp-home the counter only runs on crystal activity
    assign seq_tick = tick && (limp_q || clk_ok_s);
    assign cnt_inc = cnt_q + 13'h0001;
    assign check_hit = seq_tick && cnt_inc[`SELS_DONE_BIT] && !cnt_q[`SELS_DONE_BIT];
    assign ap = hsel && hready && htrans[1];
    assign flag_clr = wr_q && is_reg(addr_q, `SELS_OFF_STAT) && hwdata[`SELS_B_LIMP_CHG];

    always_comb begin
        ctrl_d = ctrl_q;
        clksel_d = clksel_q;
        slow_d = slow_q;
        if (wr_q && is_reg(addr_q, `SELS_OFF_CTRL)) begin
            ctrl_d = hwdata[`SELS_CTRL_W-1:0];
        end
        if (wr_q && is_reg(addr_q, `SELS_OFF_CLKSEL)) begin
            clksel_d = hwdata[1:0];
        end
        if (wr_q && is_reg(addr_q, `SELS_OFF_SLOW)) begin
            slow_d = hwdata[`SELS_SLOW_W-1:0];
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        limp_d = limp_q;
        lstat_d = lstat_q;
        pseudo_d = pseudo_q;
        relock_d = 1'b0;
        cmrst_d = 1'b0;
        unique case (st_q)
            SELS_RUN: begin
                if (stop_req) begin
                    if (no_limp && mon_any) begin
                        cmrst_d = 1'b1;
                    end else begin
                        st_d = SELS_STOP;
                        pseudo_d = ctrl_q[`SELS_B_PSEUDO_EN];
                        cnt_d = '0;
                    end
                end else if (limp_q && seq_tick) begin
                    cnt_d = cnt_inc;
                    if (check_hit && clk_ok_s) begin
                        limp_d = 1'b0;
                        lstat_d = 1'b0;
                        relock_d = auto_bw && pll_sel;
                    end
                end
            end
            SELS_STOP: begin
                if (wake_s) begin
                    cnt_d = '0;
                    if (!no_limp) begin
                        if (delay_sel) begin
                            st_d = SELS_WAIT;
                            limp_d = 1'b1;
                        end else if (clk_ok_s) begin
                            st_d = SELS_RUN;
                        end else begin
                            st_d = SELS_RUN;
                            limp_d = 1'b1;
                            lstat_d = 1'b1;
                        end
                    end else if (delay_sel) begin
                        st_d = SELS_WAIT;
                    end else if (pseudo_q) begin
                        st_d = SELS_SHORT;
                    end else begin
                        st_d = SELS_RUN;
                    end
                end
            end
            SELS_WAIT: begin
                if (cnt_q[`SELS_DONE_BIT]) begin
                    cnt_d = '0;
                    st_d = SELS_RUN;
                    pseudo_d = 1'b0;
                    if (limp_q && clk_ok_s) begin
                        limp_d = 1'b0;
                        relock_d = auto_bw && pll_sel;
                    end else if (limp_q) begin
                        lstat_d = 1'b1;
                    end
                end else if (seq_tick) begin
                    cnt_d = cnt_inc;
                end
            end
            SELS_SHORT: begin
                if (cnt_q == `SELS_SHORT_CNT) begin
                    cnt_d = '0;
                    st_d = SELS_RUN;
                    pseudo_d = 1'b0;
                end else if (seq_tick) begin
                    cnt_d = cnt_inc;
                end
            end
        endcase
        if (st_d == SELS_RUN) begin
            pseudo_d = 1'b0;
        end
        // a status change in the same cycle as the clear keeps the flag set
        flag_d = (flag_q && !flag_clr) || (lstat_d != lstat_q);
    end

    always_comb begin
        addr_d = ap ? haddr[11:0] : addr_q;
        wr_d = ap && hwrite;
        hrdata_d = hrdata_q;
        if (ap && !hwrite) begin
            hrdata_d = '0;
            if (is_reg(haddr[11:0], `SELS_OFF_CTRL)) begin
                hrdata_d[`SELS_CTRL_W-1:0] = ctrl_d;
            end else if (is_reg(haddr[11:0], `SELS_OFF_CLKSEL)) begin
                hrdata_d[1:0] = clksel_d;
            end else if (is_reg(haddr[11:0], `SELS_OFF_SLOW)) begin
                hrdata_d[`SELS_SLOW_W-1:0] = slow_d;
            end else if (is_reg(haddr[11:0], `SELS_OFF_STAT)) begin
                hrdata_d[`SELS_B_LIMP_STAT] = lstat_d;
                hrdata_d[`SELS_B_LIMP_CHG] = flag_d;
                hrdata_d[`SELS_B_STOPPED] = (st_d != SELS_RUN);
                hrdata_d[`SELS_B_PSEUDO] = pseudo_d;
                hrdata_d[`SELS_B_LIMP_FORCE] = limp_d;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= '0;
            wr_q <= 1'b0;
            hrdata_q <= '0;
            ctrl_q <= `SELS_CTRL_RST;
            clksel_q <= `SELS_CLKSEL_RST;
            slow_q <= `SELS_SLOW_RST;
            st_q <= SELS_RUN;
            cnt_q <= '0;
            limp_q <= 1'b0;
            lstat_q <= 1'b0;
            flag_q <= 1'b0;
            pseudo_q <= 1'b0;
            relock_q <= 1'b0;
            cmrst_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            wr_q <= wr_d;
            hrdata_q <= hrdata_d;
            ctrl_q <= ctrl_d;
            clksel_q <= clksel_d;
            slow_q <= slow_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            limp_q <= limp_d;
            lstat_q <= lstat_d;
            flag_q <= flag_d;
            pseudo_q <= pseudo_d;
            relock_q <= relock_d;
            cmrst_q <= cmrst_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign seq_state = st_q;
    assign chip_release = (st_q == SELS_RUN);
    assign osc_low_amplitude = (st_q == SELS_STOP) && pseudo_q;
    assign vco_run = limp_q;
    assign bus_clock_pll_select_eff = limp_q | pll_sel;
    assign module_clock_slow_select_eff = !limp_q && clksel_q[`SELS_B_SLOW_SEL];
    assign clock_monitor_enable_eff = (st_q != SELS_STOP) && (limp_q || mon_any);
    assign pll_relock_req = relock_q;
    assign clock_monitor_reset = cmrst_q;
    assign limp_home_irq_req = ctrl_q[`SELS_B_IRQ_EN] && flag_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fast_wake;
        st_q == SELS_STOP && wake_s && !delay_sel && !(no_limp && pseudo_q);
    endsequence

    sequence s_wait_done;
        st_q == SELS_WAIT && cnt_q[`SELS_DONE_BIT];
    endsequence

    property p_fast_exit;
        s_fast_wake |=> st_q == SELS_RUN && chip_release;
    endproperty
    a_fast_exit: assert property (p_fast_exit) else $error("fast exit not released");

    property p_mon_masked;
        st_q == SELS_STOP |-> !clock_monitor_enable_eff;
    endproperty
    a_mon_masked: assert property (p_mon_masked) else $error("monitor enabled in stop");

    property p_check_exit;
        st_q == SELS_RUN && !stop_req && limp_q && check_hit && clk_ok_s
            |=> !limp_q && !lstat_q && flag_q;
    endproperty
    a_check_exit: assert property (p_check_exit) else $error("limp exit flags wrong");

    property p_restore;
        !limp_q |-> bus_clock_pll_select_eff == clksel_q[`SELS_B_PLL_SEL]
            && module_clock_slow_select_eff == clksel_q[`SELS_B_SLOW_SEL];
    endproperty
    a_restore: assert property (p_restore) else $error("selects not restored");

    property p_relock;
        $fell(limp_q) && $past(auto_bw && pll_sel) |-> pll_relock_req;
    endproperty
    a_relock: assert property (p_relock) else $error("no relock after limp exit");

    property p_square_wave;
        s_fast_wake and (clk_ok_s && !no_limp && !lstat_q) |=> !lstat_q ##1 !lstat_q;
    endproperty
    a_square_wave: assert property (p_square_wave) else $error("limp status set with clock");

    property p_pseudo_osc;
        st_q == SELS_STOP && pseudo_q |-> osc_low_amplitude && !chip_release;
    endproperty
    a_pseudo_osc: assert property (p_pseudo_osc) else $error("pseudo stop oscillator off");

    property p_forced;
        st_q == SELS_WAIT && limp_q |-> bus_clock_pll_select_eff && !module_clock_slow_select_eff;
    endproperty
    a_forced: assert property (p_forced) else $error("limp forcing missing");

    property p_mon_reset;
        st_q == SELS_RUN && stop_req && no_limp && mon_any
            |=> clock_monitor_reset && st_q == SELS_RUN;
    endproperty
    a_mon_reset: assert property (p_mon_reset) else $error("no clock monitor reset");

    property p_delay_end;
        s_wait_done |=> st_q == SELS_RUN && cnt_q == '0;
    endproperty
    a_delay_end: assert property (p_delay_end) else $error("delay did not end at 4096");

    property p_irq;
        limp_home_irq_req == (ctrl_q[`SELS_B_IRQ_EN] && flag_q);
    endproperty
    a_irq: assert property (p_irq) else $error("limp interrupt mismatch");

endmodule

// File: dv/sels_osc_model.sv
/*
 * Behavioural external oscillator as seen by the clock monitor.
 * Assumes the bench switches it and sets its start-up time in hclk cycles.
 */
module sels_osc_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control from the bench
    input wire logic osc_on,
    input wire logic [15:0] start_cycles,
    // monitor result
    output logic ext_clock_present
);
    logic [15:0] run_q;

    // good only after start-up; a start-up of 0 acts as a square-wave source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 16'h0000;
        end else if (!osc_on) begin
            run_q <= 16'h0000;
        end else if (run_q != 16'hffff) begin
            run_q <= run_q + 16'h0001;
        end
    end

    assign ext_clock_present = osc_on && (run_q >= start_cycles);
endmodule

// File: dv/stop_exit_limp_home_sequencer_tb_top.sv
/*
 * Self-checking bench of the STOP-exit and limp-home sequencer.
 * Assumes the design files and the oscillator model are compiled first.
 */
`include "sels_cfg.svh"

module stop_exit_limp_home_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sels_pkg::*;
    localparam logic [31:0] A_CTRL = {20'h00000, `SELS_OFF_CTRL};
    localparam logic [31:0] A_CSEL = {20'h00000, `SELS_OFF_CLKSEL};
    localparam logic [31:0] A_SLOW = {20'h00000, `SELS_OFF_SLOW};
    localparam logic [31:0] A_STAT = {20'h00000, `SELS_OFF_STAT};
    logic hclk, hresetn, hsel, hwrite, stop_req, osc_on, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    sels_trans_t htrans;
    logic [2:0] hsize;
    logic [5:0] wake;
    logic [15:0] start_cycles;
    logic rel, low_amp, vco_run, pll_eff, slow_eff, mon_eff, relock, mon_rst, irq, clk_ok;
    logic [2:0] wait_seen;
    sels_state_e seq_state;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int relock_n = 0;

    sels_sequencer dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .stop_req(stop_req),
        .ext_reset_wake(wake[0]), .irq_pin(wake[1]), .nonmaskable_interrupt_pin(wake[2]),
        .key_wake_j(wake[3]), .key_wake_h(wake[4]), .can_wake(wake[5]),
        .ext_clock_present(clk_ok), .chip_release(rel), .osc_low_amplitude(low_amp),
        .vco_run(vco_run), .bus_clock_pll_select_eff(pll_eff),
        .module_clock_slow_select_eff(slow_eff), .clock_monitor_enable_eff(mon_eff),
        .pll_relock_req(relock), .clock_monitor_reset(mon_rst),
        .limp_home_irq_req(irq), .seq_state(seq_state)
    );

    sels_osc_model osc_u (
        .hclk(hclk), .hresetn(hresetn), .osc_on(osc_on),
        .start_cycles(start_cycles), .ext_clock_present(clk_ok)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            give_verdict();
        end
    end

    always @(negedge hclk) begin
        relock_n += (relock === 1'b1);
        if (seq_state === SELS_WAIT) wait_seen <= {vco_run, pll_eff, slow_eff};
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
            n_errors++;
        end
    endtask

    // one single transfer; called right after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hffffffff);
        logic [31:0] x;
        bus(1'b0, a, 32'h00000000, x);
        chk(what, exp, x & m);
    endtask

    task automatic do_stop();
        stop_req <= 1'b1;
        @(posedge hclk);
        stop_req <= 1'b0;
        @(negedge hclk);
    endtask

    // raise one wake source, count cycles until the chip runs, then drop it
    task automatic wake_up(input int src, input int lim, output int n);
        @(posedge hclk);
        wake[src] <= 1'b1;
        n = 0;
        while (rel !== 1'b1 && n < lim) begin
            @(negedge hclk);
            n++;
        end
        @(posedge hclk);
        wake <= 6'h00;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_regs();
        @(negedge hclk);
        chk("release after reset", 32'h1, 32'(rel));
        chk("monitor after reset", 32'h1, 32'(mon_eff));
        @(posedge hclk);
        rchk("ctrl reset", A_CTRL, {25'h0000000, `SELS_CTRL_RST});
        rchk("clksel reset", A_CSEL, 32'h0);
        rchk("slow reset", A_SLOW, 32'h0);
        rchk("stat reset", A_STAT, 32'h0);
        rchk("unmapped", 32'h00000010, 32'h0);
        chk("unmapped response okay", 32'h0, 32'(hresp));
        wr(A_SLOW, 32'h0000003f);
        rchk("slow back to back", A_SLOW, 32'h0000003f);
        wr(A_STAT, 32'h0000001f);
        rchk("stat read only", A_STAT, 32'h0);
        wr(A_SLOW, 32'h0);
    endtask

    // every wake source, prompt clock, reset wake only with a stable oscillator
    task automatic t_fast_present();
        int n;
        for (int s = 0; s < 6; s++) begin
            do_stop();
            chk("in stop", 32'(SELS_STOP), 32'(seq_state));
            chk("monitor masked", 32'h0, 32'(mon_eff));
            wake_up(s, 20, n);
            chk_rng("fast release", 1, 8, n);
            chk("no limp", 32'h0, 32'(vco_run));
        end
        rchk("status clear", A_STAT, 32'h0);
    endtask

    task automatic t_mon_reset();
        logic [31:0] cfg [3] = '{32'h00000019, 32'h0000001d, 32'h00000021};
        for (int i = 0; i < 3; i++) begin
            wr(A_CTRL, cfg[i]);
            do_stop();
            chk("monitor reset", 32'h1, 32'(mon_rst));
            chk("stays running", 32'(SELS_RUN), 32'(seq_state));
            @(negedge hclk);
            chk("reset pulse ends", 32'h0, 32'(mon_rst));
            @(posedge hclk);
        end
    endtask

    task automatic t_short();
        int n;
        int p;
        for (int s = 0; s < 4; s += 3) begin
            p = (s == 0) ? 2 : 4 * s;
            wr(A_SLOW, 32'(s));
            wr(A_CTRL, 32'h0000000d);
            do_stop();
            wake_up(3, 400, n);
            chk_rng("short wait", 15 * p, 17 * p + 8, n);
            chk("no limp clock", 32'h0, 32'(vco_run));
        end
        wr(A_SLOW, 32'h0);
        wr(A_CTRL, 32'h0000004d);
        osc_on <= 1'b0;
        start_cycles <= 16'h01f4;
        do_stop();
        @(posedge hclk);
        osc_on <= 1'b1;
        wake_up(4, 10000, n);
        chk_rng("crystal only delay", 8680, 8720, n);
        start_cycles <= 16'h0000;
    endtask

    task automatic t_fast_limp();
        int n;
        wr(A_CSEL, 32'h00000003);
        wr(A_CTRL, 32'h0000001e);
        osc_on <= 1'b0;
        do_stop();
        wake_up(1, 20, n);
        chk_rng("fast limp release", 1, 8, n);
        chk("vco restarted", 32'h1, 32'(vco_run));
        chk("monitor on in limp", 32'h1, 32'(mon_eff));
        rchk("limp status", A_STAT, 32'h00000013, 32'h00000013);
        wr(A_CSEL, 32'h00000002);
        rchk("pll select cleared", A_CSEL, 32'h00000002);
        chk("pll forced in limp", 32'h1, 32'(pll_eff));
        hresetn <= 1'b0;
        osc_on <= 1'b1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("limp cleared by reset", 32'h0, 32'(vco_run));
        chk("release after second reset", 32'h1, 32'(rel));
    endtask

    task automatic t_delay_limp();
        int n;
        wr(A_CSEL, 32'h00000003);
        wr(A_CTRL, 32'h0000005e);
        osc_on <= 1'b0;
        wait_seen <= 3'h0;
        do_stop();
        chk("low amplitude", 32'h1, 32'(low_amp));
        wake_up(2, 34000, n);
        chk_rng("limp delay", 32760, 32800, n);
        chk("forcing in wait", 32'h6, 32'(wait_seen));
        rchk("limp flags", A_STAT, 32'h00000013, 32'h00000013);
        chk("irq request", 32'h1, 32'(irq));
        start_cycles <= 16'h0064;
        osc_on <= 1'b1;
        relock_n = 0;
        n = 0;
        while (vco_run !== 1'b0 && n < 34000) begin
            @(negedge hclk);
            n++;
        end
        repeat (2) @(posedge hclk);
        chk_rng("periodic check", 32700, 32800, n);
        chk("slow restored", 32'h1, 32'(slow_eff));
        chk("pll restored", 32'h1, 32'(pll_eff));
        chk("relock once", 32'h1, 32'(relock_n));
        rchk("clock back", A_STAT, 32'h00000002, 32'h00000013);
        wr(A_CTRL, 32'h0000005c);
        @(negedge hclk);
        chk("irq masked", 32'h0, 32'(irq));
        @(posedge hclk);
        wr(A_STAT, 32'h00000002);
        rchk("flag cleared", A_STAT, 32'h0, 32'h00000013);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stop_req = 1'b0;
        wake = 6'h00;
        osc_on = 1'b1;
        start_cycles = 16'h0000;
        wait_seen = 3'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_fast_present();
        t_mon_reset();
        t_short();
        t_fast_limp();
        t_delay_limp();
        give_verdict();
    end
endmodule
